// file: rtl/macmf_pkg.sv
// package of the mac mode and receive length configuration block:
// register offsets, field positions, reset values and frame length limits.
// assumes a byte-addressed register port with 32-bit data.
package macmf_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] MODE_OFS = 12'h410;
    localparam logic [ADDR_W-1:0] RX_MAX_FRAME_CONFIG_OFS = 12'h414;
    // mode register fields
    localparam int SPD_HI = 31;
    localparam int SPD_LO = 30;
    localparam int RGMII_BIT = 29;
    localparam int SGMII_BIT = 28;
    localparam int PCS_BIT = 27;
    localparam int HOST_BIT = 26;
    localparam int TXW_BIT = 25;
    localparam int RXW_BIT = 24;
    localparam int RSV_HI = 23;
    localparam int RSV_LO = 9;
    localparam int LT_HI = 8;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [8:0] LT_RST = 9'h032;
    localparam logic [31:0] MODE_WMASK_FULL = 32'hfc00_01ff;
    localparam logic [31:0] MODE_WMASK_BASIC = 32'hc000_0000;
    // receive length register fields
    localparam int OVR_BIT = 16;
    localparam int LEN_HI = 14;
    localparam int RX_MAX_FRAME_CONFIG_W = 17;
    localparam logic [RX_MAX_FRAME_CONFIG_W-1:0] RX_MAX_FRAME_CONFIG_RST = 17'h007d0;
    localparam logic [RX_MAX_FRAME_CONFIG_W-1:0] RX_MAX_FRAME_CONFIG_WMASK = 17'h17fff;
    // frame length limits in bytes, count ceiling, vlan tag byte position and tag bytes
    localparam logic [15:0] STD_MAX = 16'h05ee;
    localparam logic [15:0] VLAN_MAX = 16'h05f2;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] TPID_POS = 16'h000c;
    localparam logic [7:0] TPID_HI = 8'h81;
    localparam logic [7:0] TPID_LO = 8'h00;
endpackage : macmf_pkg

// file: rtl/macmf_gap_hold.sv
// holding register that adopts a new configuration word only between frames.
// assumes gap_i is a same-clock level from the mac datapath.
`timescale 1ns/10ps
module macmf_gap_hold #(
    parameter int W = 32,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic gap_i,
    input wire logic [W-1:0] cfg_i,
    output logic [W-1:0] cfg_q
);
    logic [W-1:0] cfg_d;

    // adopt only in a gap so a frame never sees a half-changed mode
    always_comb begin
        cfg_d = gap_i ? cfg_i : cfg_q;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_q <= RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    property p_hold_in_frame;
        @(posedge clk) disable iff (!nrst) !gap_i |=> $stable(cfg_q);
    endproperty
    a_hold_in_frame: assert property (p_hold_in_frame) else $error("config changed inside a frame");
endmodule : macmf_gap_hold

// file: rtl/macmf_len_check.sv
// receive frame length checker: counts bytes, spots the vlan tag and
// reports each frame as good or bad against the effective limit.
// assumes one byte per rx_valid cycle and rx_last on the final byte.
`timescale 1ns/10ps
module macmf_len_check
    import macmf_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic jumbo_en,
    input wire logic vlan_en,
    input wire logic ovr_en,
    input wire logic [14:0] max_len,
    output logic frame_good_q,
    output logic frame_bad_q,
    output logic vlan_tag_q
);
    logic [15:0] cnt_q, cnt_d, len, limit;
    logic tpid_hi_q, tpid_hi_d, vlan_tag_d, good_d, bad_d, over;

    ////////////////////////////////////////////////////////////////////////////
    // byte count, tag detection and verdict
    always_comb begin
        cnt_d = cnt_q;
        tpid_hi_d = tpid_hi_q;
        vlan_tag_d = vlan_tag_q;
        len = (cnt_q == CNT_MAX) ? CNT_MAX : 16'(cnt_q + 16'h0001);
        // only 0x8100 marks a tagged frame
        if (ovr_en) begin
            limit = {1'b0, max_len};
        end else if (vlan_en && vlan_tag_q) begin
            limit = VLAN_MAX;
        end else begin
            limit = STD_MAX;
        end
        over = !jumbo_en && (len > limit);
        good_d = rx_valid && rx_last && !over;
        bad_d = rx_valid && rx_last && over;
        if (rx_valid) begin
            cnt_d = len; // saturates so a runaway frame still reads as long
            if (cnt_q == TPID_POS) begin
                tpid_hi_d = (rx_data == TPID_HI);
            end
            if (cnt_q == 16'(TPID_POS + 16'h0001)) begin
                vlan_tag_d = tpid_hi_q && (rx_data == TPID_LO);
            end
            if (rx_last) begin
                cnt_d = '0;
                tpid_hi_d = 1'b0;
                vlan_tag_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= '0;
            tpid_hi_q <= 1'b0;
            vlan_tag_q <= 1'b0;
            frame_good_q <= 1'b0;
            frame_bad_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tpid_hi_q <= tpid_hi_d;
            vlan_tag_q <= vlan_tag_d;
            frame_good_q <= good_d;
            frame_bad_q <= bad_d;
        end
    end

    property p_over_bad;
        @(posedge clk) disable iff (!nrst)
            rx_valid && rx_last && !jumbo_en && ovr_en && (len > {1'b0, max_len}) |=> frame_bad_q && !frame_good_q;
    endproperty
    a_over_bad: assert property (p_over_bad) else $error("oversize frame not flagged bad");

    property p_jumbo_free;
        @(posedge clk) disable iff (!nrst) rx_valid && rx_last && jumbo_en |=> frame_good_q;
    endproperty
    a_jumbo_free: assert property (p_jumbo_free) else $error("jumbo frame rejected");

    property p_std_limit;
        @(posedge clk) disable iff (!nrst)
            rx_valid && rx_last && !jumbo_en && !ovr_en && !vlan_tag_q && (len == 16'(STD_MAX + 16'h0001))
            |=> frame_bad_q;
    endproperty
    a_std_limit: assert property (p_std_limit) else $error("1519 byte frame passed");

    property p_tag_seen;
        @(posedge clk) disable iff (!nrst)
            rx_valid && !rx_last && (cnt_q == 16'(TPID_POS + 16'h0001)) && tpid_hi_q && (rx_data == TPID_LO)
            |=> vlan_tag_q;
    endproperty
    a_tag_seen: assert property (p_tag_seen) else $error("vlan tag missed");

    c_bad_frame: cover property (@(posedge clk) disable iff (!nrst) frame_bad_q);
    c_tagged: cover property (@(posedge clk) disable iff (!nrst) vlan_tag_q ##1 frame_good_q);
endmodule : macmf_len_check

// file: rtl/macmf_top.sv
// top of the configuration block: register port, mode and length registers,
// gap holding of both and the receive length checker.
// assumes all inputs are on clk; frame_active is high from the first to the
// last byte of any frame on the network interface.
`timescale 1ns/10ps
module macmf_top
    import macmf_pkg::*;
#(
    parameter bit PHY_IS_MII = 1'b0,
    parameter bit FULL_MODE = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic frame_active,
    input wire logic rx_jumbo_en,
    input wire logic rx_vlan_en,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic [1:0] link_speed,
    output logic rgmii_mode,
    output logic sgmii_mode,
    output logic serdes_pcs_mode_enable,
    output logic host_if_enable,
    output logic tx_wide_path_enable,
    output logic rx_wide_path_enable,
    output logic [8:0] link_timer,
    output logic rx_frame_good,
    output logic rx_frame_bad,
    output logic rx_vlan_tagged
);
    // mii cannot run at gigabit, so it comes up at 100 Mb/s
    localparam logic [1:0] SPD_RST = PHY_IS_MII ? SPD_100 : SPD_1000;
    localparam logic [31:0] WMASK = FULL_MODE ? MODE_WMASK_FULL : MODE_WMASK_BASIC;
    localparam logic [31:0] MODE_RST = ({SPD_RST, 21'h000000, LT_RST}) & WMASK;

    logic [31:0] mode_q, mode_d, mode_eff;
    logic [RX_MAX_FRAME_CONFIG_W-1:0] rx_max_frame_config_q, rx_max_frame_config_d, rx_max_frame_config_eff;
    logic [31:0] rdata_d;
    logic [31:0] reg_rdata_q;
    logic gap;
    logic hit_mode, hit_rx_max_frame_config;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    always_comb begin
        hit_mode = 1'b0;
        hit_rx_max_frame_config = 1'b0;
        if (reg_addr == MODE_OFS) begin
            hit_mode = 1'b1;
        end else if (reg_addr == RX_MAX_FRAME_CONFIG_OFS) begin
            hit_rx_max_frame_config = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes; masking keeps unsupported and reserved bits at zero
    always_comb begin
        mode_d = mode_q;
        rx_max_frame_config_d = rx_max_frame_config_q;
        if (reg_wr && hit_mode) begin
            mode_d = reg_wdata & WMASK;
        end
        if (reg_wr && hit_rx_max_frame_config) begin
            rx_max_frame_config_d = reg_wdata[RX_MAX_FRAME_CONFIG_W-1:0] & RX_MAX_FRAME_CONFIG_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_q <= MODE_RST;
            rx_max_frame_config_q <= RX_MAX_FRAME_CONFIG_RST;
        end else begin
            mode_q <= mode_d;
            rx_max_frame_config_q <= rx_max_frame_config_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: data stand in the cycle after the strobe only;
    // unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        if (reg_rd && hit_mode) begin
            rdata_d = mode_q;
        end else if (reg_rd && hit_rx_max_frame_config) begin
            rdata_d = {15'h0000, rx_max_frame_config_q};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = reg_rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // gap holding: software may write mid-frame, the datapath sees it later
    assign gap = !frame_active;

    macmf_gap_hold #(
        .W(32),
        .RST(MODE_RST)
    ) u_mode_hold (
        .clk(clk),
        .nrst(nrst),
        .gap_i(gap),
        .cfg_i(mode_q),
        .cfg_q(mode_eff)
    );

    // length config is held too, so a frame is judged by one limit throughout
    macmf_gap_hold #(
        .W(RX_MAX_FRAME_CONFIG_W),
        .RST(RX_MAX_FRAME_CONFIG_RST)
    ) u_rx_max_frame_config_hold (
        .clk(clk),
        .nrst(nrst),
        .gap_i(gap),
        .cfg_i(rx_max_frame_config_q),
        .cfg_q(rx_max_frame_config_eff)
    );

    // effective mode outputs
    assign link_speed = mode_eff[SPD_HI:SPD_LO];
    assign rgmii_mode = mode_eff[RGMII_BIT];
    assign sgmii_mode = mode_eff[SGMII_BIT];
    assign serdes_pcs_mode_enable = mode_eff[PCS_BIT];
    assign host_if_enable = mode_eff[HOST_BIT];
    assign tx_wide_path_enable = mode_eff[TXW_BIT];
    assign rx_wide_path_enable = mode_eff[RXW_BIT];
    assign link_timer = mode_eff[LT_HI:0];

    ////////////////////////////////////////////////////////////////////////////
    // receive length checking
    macmf_len_check u_len_check (
        .clk(clk),
        .nrst(nrst),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_last(rx_last),
        .jumbo_en(rx_jumbo_en),
        .vlan_en(rx_vlan_en),
        .ovr_en(rx_max_frame_config_eff[OVR_BIT]),
        .max_len(rx_max_frame_config_eff[LEN_HI:0]),
        .frame_good_q(rx_frame_good),
        .frame_bad_q(rx_frame_bad),
        .vlan_tag_q(rx_vlan_tagged)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [1:0] wr_spd;
    assign wr_spd = reg_wdata[SPD_HI:SPD_LO];

    property p_speed_adopt;
        @(posedge clk) disable iff (!nrst)
            reg_wr && hit_mode && !frame_active ##1 !frame_active |=> link_speed == $past(wr_spd, 2);
    endproperty
    a_speed_adopt: assert property (p_speed_adopt) else $error("speed not adopted in gap");

    property p_frame_hold;
        @(posedge clk) disable iff (!nrst) frame_active [*2] |=> $stable(link_speed) && $stable(link_timer);
    endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("mode changed during frame");

    property p_reset_vals;
        @(posedge clk) disable iff (!nrst)
            $rose(nrst) |-> mode_q[SPD_HI:SPD_LO] == SPD_RST && rx_max_frame_config_q == RX_MAX_FRAME_CONFIG_RST && !mode_q[HOST_BIT];
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong reset values");

    property p_mode_rsv;
        @(posedge clk) disable iff (!nrst)
            reg_rd && hit_mode |=> reg_rdata[RSV_HI:RSV_LO] == '0 && reg_rdata[TXW_BIT:RXW_BIT] == '0;
    endproperty
    a_mode_rsv: assert property (p_mode_rsv) else $error("mode reserved bits nonzero");

    property p_wide_off;
        @(posedge clk) disable iff (!nrst) !tx_wide_path_enable && !rx_wide_path_enable;
    endproperty
    a_wide_off: assert property (p_wide_off) else $error("wide data path enabled");

    property p_rx_max_frame_config_rsv;
        @(posedge clk) disable iff (!nrst)
            reg_rd && hit_rx_max_frame_config |=> reg_rdata[31:RX_MAX_FRAME_CONFIG_W] == '0 && !reg_rdata[LEN_HI + 1];
    endproperty
    a_rx_max_frame_config_rsv: assert property (p_rx_max_frame_config_rsv) else $error("length reserved bits nonzero");

    property p_basic_only_speed;
        @(posedge clk) disable iff (!nrst)
            !FULL_MODE && reg_wr && hit_mode ##1 reg_rd && hit_mode |=> reg_rdata[SPD_LO-1:0] == '0;
    endproperty
    a_basic_only_speed: assert property (p_basic_only_speed) else $error("basic mode bit writable");

    property p_len_readback;
        @(posedge clk) disable iff (!nrst)
            reg_wr && hit_rx_max_frame_config ##1 reg_rd && hit_rx_max_frame_config |=> reg_rdata[LEN_HI:0] == $past(reg_wdata[LEN_HI:0], 2);
    endproperty
    a_len_readback: assert property (p_len_readback) else $error("max length not stored");

    property p_rd_one_cycle;
        @(posedge clk) disable iff (!nrst) !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rd_one_cycle: assert property (p_rd_one_cycle) else $error("read data outside its cycle");

    ////////////////////////////////////////////////////////////////////////////
    // gap adoption checks: the effective copies follow the stored words only in gaps

    // in a gap the stored mode word reaches the outputs one edge later
    property p_mode_adopt;
        @(posedge clk) disable iff (!nrst) !frame_active |=> mode_eff == $past(mode_q);
    endproperty
    a_mode_adopt: assert property (p_mode_adopt) else $error("mode word not adopted in gap");

    property p_rx_max_frame_config_adopt;
        @(posedge clk) disable iff (!nrst) !frame_active |=> rx_max_frame_config_eff == $past(rx_max_frame_config_q);
    endproperty
    a_rx_max_frame_config_adopt: assert property (p_rx_max_frame_config_adopt) else $error("length word not adopted in gap");

    // a frame in flight must see one configuration from first byte to last
    property p_frame_hold_all;
        @(posedge clk) disable iff (!nrst) frame_active |=> $stable(mode_eff) && $stable(rx_max_frame_config_eff);
    endproperty
    a_frame_hold_all: assert property (p_frame_hold_all) else $error("effective config moved in frame");

    ////////////////////////////////////////////////////////////////////////////
    // register port checks

    // unmapped writes must leave both registers alone
    property p_wr_unmapped;
        @(posedge clk) disable iff (!nrst)
            reg_wr && !hit_mode && !hit_rx_max_frame_config |=> $stable(mode_q) && $stable(rx_max_frame_config_q);
    endproperty
    a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write changed a register");

    property p_rd_unmapped;
        @(posedge clk) disable iff (!nrst) reg_rd && !hit_mode && !hit_rx_max_frame_config |=> reg_rdata == '0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    // read data must be the stored word of the edge that took the strobe
    property p_rd_mode;
        @(posedge clk) disable iff (!nrst) reg_rd && hit_mode |=> reg_rdata == $past(mode_q);
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode read data wrong");

    property p_rd_rx_max_frame_config;
        @(posedge clk) disable iff (!nrst) reg_rd && hit_rx_max_frame_config |=> reg_rdata[RX_MAX_FRAME_CONFIG_W-1:0] == $past(rx_max_frame_config_q);
    endproperty
    a_rd_rx_max_frame_config: assert property (p_rd_rx_max_frame_config) else $error("length read data wrong");

    // the wide path bits never stick, whatever software writes
    property p_wide_store;
        @(posedge clk) disable iff (!nrst) reg_wr && hit_mode |=> !mode_q[TXW_BIT] && !mode_q[RXW_BIT];
    endproperty
    a_wide_store: assert property (p_wide_store) else $error("wide path bit stored");

    // the link timer comes up at its default only where it is writable
    property p_reset_timer;
        @(posedge clk) disable iff (!nrst)
            $rose(nrst) |-> mode_q[LT_HI:0] == (FULL_MODE ? LT_RST : 9'h000);
    endproperty
    a_reset_timer: assert property (p_reset_timer) else $error("wrong link timer reset value");

    ////////////////////////////////////////////////////////////////////////////
    // receive verdict checks

    // a verdict only follows a last byte, and never both kinds at once
    property p_verdict_src;
        @(posedge clk) disable iff (!nrst) rx_frame_good || rx_frame_bad |-> $past(rx_valid && rx_last);
    endproperty
    a_verdict_src: assert property (p_verdict_src) else $error("verdict without a last byte");

    property p_verdict_excl;
        @(posedge clk) disable iff (!nrst) !(rx_frame_good && rx_frame_bad);
    endproperty
    a_verdict_excl: assert property (p_verdict_excl) else $error("frame both good and bad");

    // the tag flag is per frame, so it must drop after each last byte
    property p_tag_clear;
        @(posedge clk) disable iff (!nrst) rx_valid && rx_last |=> !rx_vlan_tagged;
    endproperty
    a_tag_clear: assert property (p_tag_clear) else $error("vlan tag flag left set");

    // cover points of the main scenarios
    c_mode_write_in_frame: cover property (@(posedge clk) disable iff (!nrst) reg_wr && hit_mode && frame_active);
    c_speed_change: cover property (@(posedge clk) disable iff (!nrst) $changed(link_speed));
    c_override_frame: cover property (@(posedge clk) disable iff (!nrst) rx_max_frame_config_eff[OVR_BIT] && rx_frame_good);
endmodule : macmf_top

// file: testbench/tb.sv
// self-checking bench of the mac mode and receive length configuration block.
// runs macmf_top twice: full mode register on a gigabit phy, basic register on an mii phy.
`timescale 1ns/10ps
module tb;
import macmf_pkg::*;
logic clk = 1'b0;
logic nrst = 1'b0;
logic [ADDR_W-1:0] reg_addr = '0;
logic [31:0] reg_wdata = '0;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic [31:0] reg_rdata;
logic frame_active = 1'b0;
logic rx_jumbo_en = 1'b0;
logic rx_vlan_en = 1'b0;
logic rx_valid = 1'b0;
logic [7:0] rx_data = '0;
logic rx_last = 1'b0;
logic [1:0] link_speed;
logic rgmii_mode, sgmii_mode, serdes_pcs_mode_enable, host_if_enable;
logic tx_wide_path_enable, rx_wide_path_enable;
logic [8:0] link_timer;
logic rx_frame_good, rx_frame_bad, rx_vlan_tagged;
logic rd_d = 1'b0;
logic reg_rd_b = 1'b0;
logic [31:0] reg_rdata_b;
logic [1:0] link_speed_b;
logic rdb_d = 1'b0;
logic [31:0] rdb_q[$];
logic [31:0] seed = 32'h0000_005f;
logic [31:0] rd_q[$];
logic fr_q[$];
int n_errors = 0;
int compares = 0;
logic [31:0] v;

macmf_top macmf_top_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_active(frame_active),
    .rx_jumbo_en(rx_jumbo_en), .rx_vlan_en(rx_vlan_en), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .link_speed(link_speed), .rgmii_mode(rgmii_mode), .sgmii_mode(sgmii_mode),
    .serdes_pcs_mode_enable(serdes_pcs_mode_enable), .host_if_enable(host_if_enable),
    .tx_wide_path_enable(tx_wide_path_enable), .rx_wide_path_enable(rx_wide_path_enable),
    .link_timer(link_timer), .rx_frame_good(rx_frame_good), .rx_frame_bad(rx_frame_bad),
    .rx_vlan_tagged(rx_vlan_tagged));

// basic configuration on an mii phy; shares the bus but reads with its own strobe
if (1) begin : g_basic
    macmf_top #(.PHY_IS_MII(1'b1), .FULL_MODE(1'b0)) macmf_top_inst (.clk(clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd_b),
        .reg_rdata(reg_rdata_b), .frame_active(frame_active), .rx_jumbo_en(rx_jumbo_en),
        .rx_vlan_en(rx_vlan_en), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .link_speed(link_speed_b), .rgmii_mode(), .sgmii_mode(), .serdes_pcs_mode_enable(),
        .host_if_enable(), .tx_wide_path_enable(), .rx_wide_path_enable(), .link_timer(),
        .rx_frame_good(), .rx_frame_bad(), .rx_vlan_tagged());
end

// 40 MHz clock
always #12.5 clk = ~clk;

////////////////////////////////////////////////////////////////////////////////
// shared tasks

function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction : xs

task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
        n_errors++;
        $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
endtask : chk

task automatic end_of_test();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
        $display("Simulation passed");
    end else begin
        $display("Simulation failed");
    end
    $finish;
endtask : end_of_test

task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
endtask : reg_write

// the expected word is queued; the monitor compares it when the data stand
task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(exp);
    @(posedge clk);
    reg_rd <= 1'b0;
endtask : reg_read

// write then read with no gap; to_b selects which instance takes the read
task automatic reg_wr_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] exp, input logic to_b);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (to_b) begin
        reg_rd_b <= 1'b1;
        rdb_q.push_back(exp);
    end else begin
        reg_rd <= 1'b1;
        rd_q.push_back(exp);
    end
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_rd_b <= 1'b0;
endtask : reg_wr_rd

// effective mode outputs packed into the register layout for one compare
task automatic chk_mode(input logic [31:0] exp);
    @(negedge clk);
    chk("mode outputs", exp, {link_speed, rgmii_mode, sgmii_mode, serdes_pcs_mode_enable, host_if_enable,
        tx_wide_path_enable, rx_wide_path_enable, 15'h0000, link_timer});
    @(posedge clk);
endtask : chk_mode

// one frame, type field at bytes 12 and 13, waits a bounded time for its verdict
task automatic send(input int len, input logic [15:0] tpid, input logic good);
    int k;
    fr_q.push_back(good);
    for (int i = 0; i < len; i++) begin
        @(posedge clk);
        frame_active <= 1'b1;
        rx_valid <= 1'b1;
        rx_data <= (i == 12) ? tpid[15:8] : (i == 13) ? tpid[7:0] : 8'(xs());
        rx_last <= (i == len - 1);
        if (i == 20) begin
            @(negedge clk);
            chk("vlan tag flag", {31'h0, tpid === 16'h8100}, {31'h0, rx_vlan_tagged});
        end
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    frame_active <= 1'b0;
    k = 0;
    while (fr_q.size() != 0 && k < 10) begin
        @(negedge clk);
        k++;
    end
    // back on the rising edge so the caller drives inputs there
    @(posedge clk);
    if (fr_q.size() != 0) begin
        chk("frame verdict timeout", 32'h1, 32'h0);
        end_of_test();
    end
endtask : send

////////////////////////////////////////////////////////////////////////////////
// monitor: takes the oldest note whenever read data or a verdict appear

always @(posedge clk) begin
    rd_d <= reg_rd;
    rdb_d <= reg_rd_b;
end

always @(negedge clk) begin
    if (rd_d) begin
        if (rd_q.size() == 0) chk("unexpected read", 32'h0, 32'h1);
        else chk("read data", rd_q.pop_front(), reg_rdata);
    end
    if (rdb_d) begin
        if (rdb_q.size() == 0) chk("unexpected basic read", 32'h0, 32'h1);
        else chk("basic read data", rdb_q.pop_front(), reg_rdata_b);
    end
    if (rx_frame_good === 1'b1 || rx_frame_bad === 1'b1) begin
        if (fr_q.size() == 0) chk("unexpected verdict", 32'h0, 32'h1);
        else chk("good bad pulses", {30'h0, fr_q[0], ~fr_q[0]}, {30'h0, rx_frame_good, rx_frame_bad});
        if (fr_q.size() != 0) void'(fr_q.pop_front());
    end
end

// hang guard
initial begin
    repeat (100000) @(posedge clk);
    chk("run time limit", 32'h1, 32'h0);
    end_of_test();
end

////////////////////////////////////////////////////////////////////////////////
// main sequence

initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // reset values and unmapped places
    reg_read(MODE_OFS, {SPD_1000, 21'h000000, LT_RST});
    reg_read(RX_MAX_FRAME_CONFIG_OFS, 32'h0000_07d0);
    chk_mode({SPD_1000, 21'h000000, LT_RST});
    chk("basic reset speed", {30'h0, SPD_100}, {30'h0, link_speed_b});
    reg_write(12'h418, 32'hffff_ffff);
    reg_read(12'h418, 32'h0000_0000);
    reg_read(12'h40c, 32'h0000_0000);
    $display("test reset values done");
    // write during a frame is stored but held off until the gap
    frame_active <= 1'b1;
    reg_write(MODE_OFS, 32'hffff_ffff);
    reg_read(MODE_OFS, 32'hfc00_01ff);
    repeat (5) @(posedge clk);
    chk_mode({SPD_1000, 21'h000000, LT_RST});
    frame_active <= 1'b0;
    repeat (3) @(posedge clk);
    chk_mode(32'hfc00_01ff);
    $display("test gap adoption done");
    // basic configuration: only the speed field sticks
    reg_wr_rd(MODE_OFS, 32'hbfff_ffff, {SPD_1000, 30'h0}, 1'b1);
    @(negedge clk);
    chk("basic speed", {30'h0, SPD_1000}, {30'h0, link_speed_b});
    // every speed code with random other fields
    for (int s = 0; s < 4; s++) begin
        v = xs();
        v[SPD_HI:SPD_LO] = s[1:0];
        reg_write(MODE_OFS, v);
        reg_read(MODE_OFS, v & MODE_WMASK_FULL);
        repeat (2) @(posedge clk);
        chk_mode(v & MODE_WMASK_FULL);
    end
    reg_wr_rd(RX_MAX_FRAME_CONFIG_OFS, 32'hffff_ffff, 32'h0001_7fff, 1'b0);
    reg_write(RX_MAX_FRAME_CONFIG_OFS, 32'h0000_07d0);
    $display("test mode fields done");
    // standard limits, tag recognition
    repeat (3) @(posedge clk);
    send(1518, 16'h0800, 1'b1);
    send(1519, 16'h0800, 1'b0);
    rx_vlan_en <= 1'b1;
    send(1522, 16'h8100, 1'b1);
    send(1523, 16'h8100, 1'b0);
    send(1519, 16'h8101, 1'b0);
    rx_vlan_en <= 1'b0;
    send(1522, 16'h8100, 1'b0);
    $display("test standard limits done");
    // override with a short programmed length, vlan setting ignored
    reg_write(RX_MAX_FRAME_CONFIG_OFS, 32'h0001_0064);
    rx_vlan_en <= 1'b1;
    repeat (3) @(posedge clk);
    send(100, 16'h8100, 1'b1);
    send(101, 16'h8100, 1'b0);
    rx_vlan_en <= 1'b0;
    send(101, 16'h0800, 1'b0);
    // jumbo acceptance overrides the length register
    rx_jumbo_en <= 1'b1;
    send(3000, 16'h0800, 1'b1);
    $display("test override and jumbo done");
    repeat (4) @(posedge clk);
    chk("queues drained", 32'h0, rd_q.size() + fr_q.size() + rdb_q.size());
    end_of_test();
end
endmodule : tb
